// [xfer_desc_params.svh]
// Offsets, field positions, reset values and counts for the descriptor engine
`ifndef XFER_DESC_PARAMS_SVH
`define XFER_DESC_PARAMS_SVH
`define NUM_DESC 24
`define LAST_DESC 5'h17
`define RG_ENABLE0 8'h00
`define RG_ENABLE1 8'h01
`define RG_ENABLE2 8'h02
`define RG_STATUS 8'h03
`define DESC_AREA 8'h40
`define AREA_IDX 5'h08
`define F_CTRL 3'h0
`define F_BLOCK 3'h1
`define F_COUNT 3'h2
`define F_RELOAD 3'h3
`define F_SRC_LO 3'h4
`define F_SRC_HI 3'h5
`define F_DST_LO 3'h6
`define F_DST_HI 3'h7
`define CTRL_MASK 8'h7F
`define COUNT_LAST 8'h01
`define COUNT_STEP 8'h01
`define UNITS_FULL 9'h100
`define UNIT_STEP 9'h001
`define STEP_BYTE 16'h0001
`define STEP_HALF 16'h0002
`define ZERO8 8'h00
`define ZERO16 16'h0000
`endif

// [desc_pkg.sv]
// Types shared by the descriptor engine modules
`default_nettype none
package desc_pkg;
   typedef struct packed {
      logic zero;
      logic unit16;
      logic rpt_irq;
      logic chain;
      logic dst_step;
      logic src_step;
      logic rpt_src;
      logic repeat_md;
   } ctrl_t;
   typedef struct packed {
      ctrl_t ctrl;
      logic [7:0] block;
      logic [7:0] count;
      logic [7:0] reload;
      logic [15:0] src;
      logic [15:0] dst;
      logic [15:0] src_home;
      logic [15:0] dst_home;
   } desc_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic wide;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_cmd_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READ = 4'h2,
      ST_WRITE = 4'h4,
      ST_FINISH = 4'h8
   } state_t;
endpackage
`default_nettype wire

// [xfer_arbiter.sv]
// Fixed-priority pick among pending, enabled activation sources
`timescale 1ns/1ns
`default_nettype none
`include "xfer_desc_params.svh"
module xfer_arbiter (
   // Requests
   input wire logic [`NUM_DESC-1:0] pending,
   input wire logic [`NUM_DESC-1:0] enable,
   // Choice
   output logic grant,
   output logic [4:0] grant_idx
);
   function automatic logic [4:0] first_set(input logic [`NUM_DESC-1:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = `NUM_DESC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      grant = |(pending & enable);
      grant_idx = first_set(pending & enable);
   end
endmodule
`default_nettype wire

// [addr_stepper.sv]
// Effective and next source/destination addresses for one unit
`timescale 1ns/1ns
`default_nettype none
`include "xfer_desc_params.svh"
module addr_stepper (
   // Descriptor view
   input wire desc_pkg::ctrl_t ctrl,
   input wire logic [15:0] src,
   input wire logic [15:0] dst,
   // Addresses
   output logic [15:0] src_eff,
   output logic [15:0] dst_eff,
   output logic [15:0] src_next,
   output logic [15:0] dst_next,
   output logic src_inc,
   output logic dst_inc
);
   // Halfword units drop the lowest address bit
   function automatic logic [15:0] align(input logic [15:0] a, input logic wide);
      return wide ? {a[15:1], 1'b0} : a; // [RQ15] [RQ18]
   endfunction

   logic [15:0] step;

   always_comb begin
      step = ctrl.unit16 ? `STEP_HALF : `STEP_BYTE; // [RQ1]
      // The repeat area always advances; its stepping bit is ignored
      src_inc = (ctrl.repeat_md & ctrl.rpt_src) | ctrl.src_step; // [RQ7] [RQ8] [RQ9]
      dst_inc = (ctrl.repeat_md & ~ctrl.rpt_src) | ctrl.dst_step; // [RQ5] [RQ6] [RQ9]
      src_eff = align(src, ctrl.unit16);
      dst_eff = align(dst, ctrl.unit16);
      src_next = src_inc ? src_eff + step : src;
      dst_next = dst_inc ? dst_eff + step : dst;
   end
endmodule
`default_nettype wire

// [xfer_desc_decoder.sv]
// Descriptor store and transfer sequencer for 24 transfer channels
// How it works
// RQ1: Unit size bit picks 8 or 16 bits
// RQ2: Repeat end interrupt only with enable bit
// RQ3: Chain enable continues with a chained transfer
// RQ4: Software leaves chaining off in descriptor 23
// RQ5: Destination stepping bit fixes or advances destination
// RQ6: Destination repeat area ignores destination stepping
// RQ7: Source stepping bit fixes or advances source
// RQ8: Source repeat area ignores source stepping
// RQ9: Repeat side bit picks area, repeat only
// RQ10: Mode bit selects normal or repeat
// RQ11: Block size counts units; zero means 256
// RQ12: Count drops each activation; zero means 256
// RQ13: Repeat mode reloads count from reload field
// RQ14: Software sets reload equal to initial count
// RQ15: Halfword source address ignores lowest bit
// RQ16: Software keeps source out of register space
// RQ17: Transfers never touch descriptor fields
// RQ18: Halfword destination address ignores lowest bit
// RQ19: Descriptor fields laid out in fixed order
// RQ20: End interrupt condition clears activation enable
// RQ21: Chained descriptor runs at once, no activation
// RQ22: Repeat side address returns home at count end
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "xfer_desc_params.svh"
module xfer_desc_decoder (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // Activation sources
   input wire logic [`NUM_DESC-1:0] ACT_REQ,
   // Memory master
   output desc_pkg::mem_cmd_t MEM_CMD,
   input wire logic MEM_ACK,
   input wire logic [15:0] MEM_RDATA,
   // Status
   output logic [`NUM_DESC-1:0] END_IRQ,
   output logic BUSY
);
   desc_pkg::desc_t desc_r [`NUM_DESC];
   desc_pkg::desc_t desc_nxt [`NUM_DESC];
   desc_pkg::desc_t cd;
   desc_pkg::state_t st_r, st_nxt;
   desc_pkg::mem_cmd_t cmd_r, cmd_nxt;
   logic [`NUM_DESC-1:0] en_r, en_nxt, pend_r, pend_nxt, irq_r, irq_nxt, served;
   logic [4:0] cur_r, cur_nxt, widx, grant_idx;
   logic [8:0] units_r, units_nxt;
   logic [15:0] data_r, data_nxt, src_eff, dst_eff, src_next, dst_next;
   logic [7:0] rdata_r, rdata_nxt;
   logic grant, in_area, last, end_ev, src_inc, dst_inc;

   // Units per activation; a zero block size means 256
   function automatic logic [8:0] units_of(input logic [7:0] b);
      return (b == `ZERO8) ? `UNITS_FULL : {1'b0, b}; // [RQ11]
   endfunction

   function automatic desc_pkg::desc_t put_byte(input desc_pkg::desc_t d,
                                                input logic [2:0] f,
                                                input logic [7:0] v);
      desc_pkg::desc_t r;
      r = d;
      case (f) // [RQ19]
         `F_CTRL: r.ctrl = desc_pkg::ctrl_t'(v & `CTRL_MASK);
         `F_BLOCK: r.block = v;
         `F_COUNT: r.count = v;
         `F_RELOAD: r.reload = v;
         `F_SRC_LO: begin
            r.src[7:0] = v;
            r.src_home[7:0] = v;
         end
         `F_SRC_HI: begin
            r.src[15:8] = v;
            r.src_home[15:8] = v;
         end
         `F_DST_LO: begin
            r.dst[7:0] = v;
            r.dst_home[7:0] = v;
         end
         `F_DST_HI: begin
            r.dst[15:8] = v;
            r.dst_home[15:8] = v;
         end
         default: r = d;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] get_byte(input desc_pkg::desc_t d, input logic [2:0] f);
      logic [7:0] r;
      r = `ZERO8;
      case (f) // [RQ19]
         `F_CTRL: r = d.ctrl;
         `F_BLOCK: r = d.block;
         `F_COUNT: r = d.count;
         `F_RELOAD: r = d.reload;
         `F_SRC_LO: r = d.src[7:0];
         `F_SRC_HI: r = d.src[15:8];
         `F_DST_LO: r = d.dst[7:0];
         `F_DST_HI: r = d.dst[15:8];
         default: r = `ZERO8;
      endcase
      return r;
   endfunction

   xfer_arbiter u_arb (
      .pending(pend_r),
      .enable(en_r),
      .grant(grant),
      .grant_idx(grant_idx)
   );

   addr_stepper u_step (
      .ctrl(cd.ctrl),
      .src(cd.src),
      .dst(cd.dst),
      .src_eff(src_eff),
      .dst_eff(dst_eff),
      .src_next(src_next),
      .dst_next(dst_next),
      .src_inc(src_inc),
      .dst_inc(dst_inc)
   );

   always_comb begin
      cd = desc_r[cur_r];
      in_area = REG_ADDR >= `DESC_AREA;
      widx = REG_ADDR[7:3] - `AREA_IDX;
      desc_nxt = desc_r;
      en_nxt = en_r;
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      cur_nxt = cur_r;
      units_nxt = units_r;
      data_nxt = data_r;
      irq_nxt = '0;
      served = '0;
      last = cd.count == `COUNT_LAST;
      end_ev = 1'b0;
      // Software side
      if (REG_WR) begin
         if (in_area) begin
            desc_nxt[widx] = put_byte(desc_r[widx], REG_ADDR[2:0], REG_WDATA);
         end else begin
            case (REG_ADDR)
               `RG_ENABLE0: en_nxt[7:0] = REG_WDATA;
               `RG_ENABLE1: en_nxt[15:8] = REG_WDATA;
               `RG_ENABLE2: en_nxt[23:16] = REG_WDATA;
               default: en_nxt = en_nxt;
            endcase
         end
      end
      rdata_nxt = `ZERO8;
      if (REG_RD) begin
         if (in_area) begin
            rdata_nxt = get_byte(desc_r[widx], REG_ADDR[2:0]);
         end else begin
            case (REG_ADDR)
               `RG_ENABLE0: rdata_nxt = en_r[7:0];
               `RG_ENABLE1: rdata_nxt = en_r[15:8];
               `RG_ENABLE2: rdata_nxt = en_r[23:16];
               `RG_STATUS: rdata_nxt = {~st_r[0], 2'b00, cur_r};
               default: rdata_nxt = `ZERO8;
            endcase
         end
      end
      // Sequencer; descriptor fields are never a transfer target
      case (st_r)
         desc_pkg::ST_IDLE: begin
            if (grant) begin
               served[grant_idx] = 1'b1;
               cur_nxt = grant_idx;
               units_nxt = units_of(desc_r[grant_idx].block);
               st_nxt = desc_pkg::ST_READ;
            end
         end
         desc_pkg::ST_READ: begin
            if (!cmd_r.valid) begin
               cmd_nxt = '{valid: 1'b1, write: 1'b0, wide: cd.ctrl.unit16,
                           addr: src_eff, wdata: `ZERO16}; // [RQ1] [RQ15]
            end else if (MEM_ACK) begin
               data_nxt = cd.ctrl.unit16 ? MEM_RDATA : {8'h00, MEM_RDATA[7:0]};
               cmd_nxt.valid = 1'b0;
               st_nxt = desc_pkg::ST_WRITE;
            end
         end
         desc_pkg::ST_WRITE: begin
            if (!cmd_r.valid) begin
               cmd_nxt = '{valid: 1'b1, write: 1'b1, wide: cd.ctrl.unit16,
                           addr: dst_eff, wdata: data_r}; // [RQ1] [RQ18]
            end else if (MEM_ACK) begin
               desc_nxt[cur_r].src = src_next; // [RQ7] [RQ8]
               desc_nxt[cur_r].dst = dst_next; // [RQ5] [RQ6]
               cmd_nxt.valid = 1'b0;
               units_nxt = units_r - `UNIT_STEP; // [RQ11]
               st_nxt = (units_r == `UNIT_STEP) ? desc_pkg::ST_FINISH : desc_pkg::ST_READ;
            end
         end
         desc_pkg::ST_FINISH: begin
            desc_nxt[cur_r].count = cd.count - `COUNT_STEP; // [RQ12]
            if (last) begin
               if (cd.ctrl.repeat_md) begin // [RQ10]
                  desc_nxt[cur_r].count = cd.reload; // [RQ13]
                  if (cd.ctrl.rpt_src) begin // [RQ9]
                     desc_nxt[cur_r].src = cd.src_home; // [RQ22]
                  end else begin
                     desc_nxt[cur_r].dst = cd.dst_home; // [RQ22]
                  end
                  end_ev = cd.ctrl.rpt_irq; // [RQ2]
               end else begin
                  end_ev = 1'b1;
               end
            end
            if (end_ev) begin
               irq_nxt[cur_r] = 1'b1;
               en_nxt[cur_r] = 1'b0; // [RQ20]
            end
            // Descriptor 23 never chains past the end of the table
            if (cd.ctrl.chain && cur_r != `LAST_DESC) begin // [RQ3] [RQ4]
               cur_nxt = cur_r + 5'h01; // [RQ21]
               units_nxt = units_of(desc_r[cur_r + 5'h01].block);
               st_nxt = desc_pkg::ST_READ;
            end else begin
               st_nxt = desc_pkg::ST_IDLE;
            end
         end
         default: st_nxt = desc_pkg::ST_IDLE;
      endcase
      // A new request in the serving cycle stays pending
      pend_nxt = (pend_r & ~served) | (ACT_REQ & en_r);
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < `NUM_DESC; i++) begin
            desc_r[i] <= '0;
         end
         st_r <= desc_pkg::ST_IDLE;
         cmd_r <= '0;
         en_r <= '0;
         pend_r <= '0;
         irq_r <= '0;
         cur_r <= 5'h00;
         units_r <= 9'h000;
         data_r <= `ZERO16;
         rdata_r <= `ZERO8;
      end else begin
         desc_r <= desc_nxt;
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         en_r <= en_nxt;
         pend_r <= pend_nxt;
         irq_r <= irq_nxt;
         cur_r <= cur_nxt;
         units_r <= units_nxt;
         data_r <= data_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   always_comb begin
      MEM_CMD = cmd_r;
      END_IRQ = irq_r;
      REG_RDATA = rdata_r;
      BUSY = ~st_r[0];
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   logic fin;
   assign fin = st_r == desc_pkg::ST_FINISH;

   a_unit_width_sel: assert property (cmd_r.valid |-> cmd_r.wide == cd.ctrl.unit16) // [RQ1]
      else $error("unit width differs from descriptor");
   a_wide_addr_even: assert property (cmd_r.valid && cmd_r.wide |-> !cmd_r.addr[0]) // [RQ15]
      else $error("halfword access on odd address");
   a_repeat_irq_gate: assert property (fin && cd.ctrl.repeat_md && !cd.ctrl.rpt_irq
      |=> END_IRQ == '0) // [RQ2]
      else $error("repeat end interrupt without enable");
   a_normal_end_irq: assert property (fin && !cd.ctrl.repeat_md && last
      |=> END_IRQ[$past(cur_r)] && !en_r[$past(cur_r)]) // [RQ20]
      else $error("normal end did not raise interrupt and disable");
   a_chain_next_desc: assert property (fin && cd.ctrl.chain && cur_r != `LAST_DESC
      |=> st_r == desc_pkg::ST_READ && cur_r == $past(cur_r) + 5'h01) // [RQ3]
      else $error("chain did not continue with next descriptor");
   a_count_decrement: assert property (fin && !last
      |=> desc_r[$past(cur_r)].count == $past(cd.count) - `COUNT_STEP) // [RQ12]
      else $error("transfer count not decremented");
   a_count_reload: assert property (fin && last && cd.ctrl.repeat_md
      |=> desc_r[$past(cur_r)].count == $past(cd.reload)) // [RQ13]
      else $error("repeat count not reloaded");
   a_dst_fixed_hold: assert property (st_r == desc_pkg::ST_WRITE && cmd_r.valid && MEM_ACK
      && !cd.ctrl.dst_step && !(cd.ctrl.repeat_md && !cd.ctrl.rpt_src)
      |=> desc_r[$past(cur_r)].dst == $past(cd.dst)) // [RQ5]
      else $error("fixed destination moved");
   a_src_fixed_hold: assert property (st_r == desc_pkg::ST_WRITE && cmd_r.valid && MEM_ACK
      && !cd.ctrl.src_step && !(cd.ctrl.repeat_md && cd.ctrl.rpt_src)
      |=> desc_r[$past(cur_r)].src == $past(cd.src)) // [RQ7]
      else $error("fixed source moved");
   a_repeat_home: assert property (fin && last && cd.ctrl.repeat_md && cd.ctrl.rpt_src
      |=> desc_r[$past(cur_r)].src == $past(cd.src_home)) // [RQ22]
      else $error("repeat source not returned home");

   c_chain_run: cover property (fin && cd.ctrl.chain ##1 st_r == desc_pkg::ST_READ);
   c_repeat_reload: cover property (fin && last && cd.ctrl.repeat_md);
   c_halfword_write: cover property (cmd_r.valid && cmd_r.write && cmd_r.wide && MEM_ACK);
endmodule
`default_nettype wire

// [xfer_mem_model.sv]
// Behavioural memory on the far side of the engine's command port
`timescale 1ns/1ns
`default_nettype none
module xfer_mem_model (
   // Clock
   input wire logic clk,
   // Command port
   input wire desc_pkg::mem_cmd_t cmd,
   input wire logic [1:0] lat,
   output logic ack,
   output logic [15:0] rdata
);
   // Data space only: descriptor fields live elsewhere and are never reached
   logic [7:0] mem [0:65535];
   logic [1:0] wait_r = 2'h0;
   logic [15:0] last_r = 16'h0000;
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ 8'hA5;
      end
   end
   // Accept after lat idle cycles so prompt and slow answers are both exercised
   assign ack = cmd.valid && (wait_r == lat);
   // Outside an accepted read the data lines show a changing pattern
   always_comb begin
      rdata = ~last_r;
      if (ack && !cmd.write) begin
         rdata = {cmd.wide ? mem[cmd.addr + 16'h0001] : ~last_r[15:8], mem[cmd.addr]};
      end
   end
   always @(posedge clk) begin
      wait_r <= (cmd.valid && !ack) ? wait_r + 2'h1 : 2'h0;
      last_r <= rdata;
      if (ack && cmd.write) begin
         mem[cmd.addr] <= cmd.wdata[7:0];
         if (cmd.wide) begin
            mem[cmd.addr + 16'h0001] <= cmd.wdata[15:8];
         end
      end
   end
endmodule
`default_nettype wire

// [transfer_descriptor_decoder_bench.sv]
// Self-checking bench for the transfer descriptor decoder
`timescale 1ns/1ns
`default_nettype none
`include "xfer_desc_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module transfer_descriptor_decoder_bench;
   logic clk;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [23:0] act_req;
   desc_pkg::mem_cmd_t mem_cmd;
   logic mem_ack;
   logic [15:0] mem_rdata;
   logic [23:0] end_irq;
   logic busy;
   logic [1:0] lat;
   logic [7:0] v;
   logic busy_seen;
   int err_count;
   int checks;
   int irq_cnt [24];
   xfer_desc_decoder dut_u (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .ACT_REQ(act_req), .MEM_CMD(mem_cmd), .MEM_ACK(mem_ack), .MEM_RDATA(mem_rdata),
      .END_IRQ(end_irq), .BUSY(busy));
   xfer_mem_model mem_u (.clk(clk), .cmd(mem_cmd), .lat(lat), .ack(mem_ack),
      .rdata(mem_rdata));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      for (int i = 0; i < 24; i++) begin
         if (rst_n && end_irq[i] === 1'b1) irq_cnt[i]++;
      end
   end
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction
   function automatic logic [7:0] fa(input int j, input logic [2:0] f);
      return `DESC_AREA + 8'(j * 8) + {5'h00, f};
   endfunction
   task automatic test_done();
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a, v);
      `CHK(v, e)
   endtask
   task automatic rd16c(input int j, input logic [2:0] f, input logic [15:0] e);
      logic [7:0] lo;
      rd(fa(j, f), lo);
      rd(fa(j, f + 3'h1), v);
      `CHK({v, lo}, e)
   endtask
   task automatic enb(input int j, input logic e);
      rd(`RG_ENABLE0 + 8'(j / 8), v);
      `CHK(v[j % 8], e)
   endtask
   task automatic en(input int j);
      rd(`RG_ENABLE0 + 8'(j / 8), v);
      wr(`RG_ENABLE0 + 8'(j / 8), v | (8'h01 << (j % 8)));
   endtask
   task automatic setd(input int j, input logic [7:0] c, input logic [7:0] b,
      input logic [7:0] n, input logic [7:0] r, input logic [15:0] s, input logic [15:0] d);
      wr(fa(j, `F_CTRL), c);
      wr(fa(j, `F_BLOCK), b);
      wr(fa(j, `F_COUNT), n);
      wr(fa(j, `F_RELOAD), r);
      wr(fa(j, `F_SRC_LO), s[7:0]);
      wr(fa(j, `F_SRC_HI), s[15:8]);
      wr(fa(j, `F_DST_LO), d[7:0]);
      wr(fa(j, `F_DST_HI), d[15:8]);
   endtask
   // Pulse one activation source, then wait for the sequencer to go idle
   task automatic fire(input int j);
      int n;
      @(posedge clk);
      act_req[j] <= 1'b1;
      @(posedge clk);
      act_req[j] <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      n = 0;
      busy_seen = 1'b0;
      while (busy !== 1'b0) begin
         n++;
         busy_seen = 1'b1;
         if (n > 5000) begin
            err_count++;
            test_done();
         end
         @(posedge clk);
         #1;
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic chkmem(input logic [15:0] d, input logic [15:0] s, input int n);
      for (int i = 0; i < n; i++) `CHK(mem_u.mem[d + 16'(i)], pat(s + 16'(i)))
   endtask
   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      act_req = 24'h000000;
      lat = 2'h0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // Register map, field order, reserved control bit, unmapped place
      rdc(fa(5, `F_CTRL), 8'h00);
      for (int f = 0; f < 8; f++) wr(fa(5, f[2:0]), 8'hF0 + 8'(f));
      for (int f = 0; f < 8; f++) rdc(fa(5, f[2:0]), f == 0 ? 8'h70 : 8'hF0 + 8'(f));
      @(posedge clk);
      #1;
      `CHK(reg_rdata, 8'h00)
      wr(8'h10, 8'h5A);
      rdc(8'h10, 8'h00);
      wr(`RG_ENABLE1, 8'hC3);
      rdc(`RG_ENABLE1, 8'hC3);
      wr(`RG_ENABLE1, 8'h00);
      rd(`RG_STATUS, v);
      `CHK(v[7], 1'b0)
      // Normal mode, both sides stepping, two activations
      setd(0, 8'h0C, 8'h03, 8'h02, 8'h00, 16'h1000, 16'h2000);
      en(0);
      fire(0);
      chkmem(16'h2000, 16'h1000, 3);
      `CHK(busy_seen, 1'b1)
      rdc(fa(0, `F_COUNT), 8'h01);
      rd16c(0, `F_SRC_LO, 16'h1003);
      `CHK(irq_cnt[0], 0)
      enb(0, 1'b1);
      fire(0);
      chkmem(16'h2003, 16'h1003, 3);
      `CHK(irq_cnt[0], 1)
      enb(0, 1'b0);
      fire(0);
      chkmem(16'h2006, 16'h2006, 1);
      `CHK(busy_seen, 1'b0)
      // Fixed destination, then fixed source, with a slow memory
      lat = 2'h2;
      setd(1, 8'h04, 8'h02, 8'h01, 8'h00, 16'h1100, 16'h2100);
      setd(2, 8'h08, 8'h02, 8'h01, 8'h00, 16'h1200, 16'h2200);
      en(1);
      en(2);
      fire(1);
      fire(2);
      chkmem(16'h2100, 16'h1101, 1);
      chkmem(16'h2101, 16'h2101, 1);
      chkmem(16'h2200, 16'h1200, 1);
      chkmem(16'h2201, 16'h1200, 1);
      // Halfword units from odd addresses
      lat = 2'h1;
      setd(3, 8'h4C, 8'h02, 8'h01, 8'h00, 16'h3001, 16'h4003);
      en(3);
      fire(3);
      chkmem(16'h4002, 16'h3000, 4);
      chkmem(16'h4006, 16'h4006, 1);
      // Repeat mode, destination area, stepping bit clear and no interrupt
      setd(4, 8'h05, 8'h01, 8'h02, 8'h02, 16'h1400, 16'h5000);
      en(4);
      fire(4);
      fire(4);
      chkmem(16'h5000, 16'h1400, 2);
      rdc(fa(4, `F_COUNT), 8'h02);
      rd16c(4, `F_DST_LO, 16'h5000);
      `CHK(irq_cnt[4], 0)
      enb(4, 1'b1);
      fire(4);
      chkmem(16'h5000, 16'h1402, 1);
      // Repeat mode, source area, interrupt enabled
      setd(5, 8'h2B, 8'h02, 8'h01, 8'h01, 16'h1500, 16'h5100);
      en(5);
      fire(5);
      chkmem(16'h5100, 16'h1500, 2);
      rd16c(5, `F_SRC_LO, 16'h1500);
      rdc(fa(5, `F_COUNT), 8'h01);
      `CHK(irq_cnt[5], 1)
      enb(5, 1'b0);
      // Chain from 6 into 7; 7 stops the chain so 8 stays untouched
      setd(6, 8'h1C, 8'h01, 8'h01, 8'h00, 16'h1600, 16'h5200);
      setd(7, 8'h0C, 8'h01, 8'h01, 8'h00, 16'h1700, 16'h5300);
      setd(8, 8'h0C, 8'h01, 8'h01, 8'h00, 16'h1800, 16'h5400);
      en(6);
      fire(6);
      chkmem(16'h5200, 16'h1600, 1);
      chkmem(16'h5300, 16'h1700, 1);
      chkmem(16'h5400, 16'h5400, 1);
      rdc(`RG_STATUS, 8'h07);
      // Last descriptor: block 00 is 256 units, count 00 is 256 activations
      setd(23, 8'h0C, 8'h00, 8'h00, 8'h00, 16'h6000, 16'h8000);
      en(23);
      fire(23);
      chkmem(16'h80FF, 16'h60FF, 1);
      chkmem(16'h8100, 16'h8100, 1);
      rd16c(23, `F_DST_LO, 16'h8100);
      rdc(fa(23, `F_COUNT), 8'hFF);
      wr(fa(23, `F_BLOCK), 8'h01);
      for (int k = 0; k < 254; k++) fire(23);
      rdc(fa(23, `F_COUNT), 8'h01);
      `CHK(irq_cnt[23], 0)
      fire(23);
      `CHK(irq_cnt[23], 1)
      enb(23, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
